// [core/cgs_defines.svh]
// Register offsets, field positions, reset values and timing for the clock status block
`ifndef CGS_DEFINES_SVH
`define CGS_DEFINES_SVH
// Register byte offsets
`define CGS_ADR_STATUS1   8'h00
`define CGS_ADR_STATUS2   8'h04
`define CGS_ADR_FLT_UPPER 8'h08
`define CGS_ADR_FLT_LOWER 8'h0c
`define CGS_ADR_TRIM      8'h10
`define CGS_ADR_CONTROL   8'h14
// Status one fields
`define CGS_ST1_MODE_HI   7
`define CGS_ST1_MODE_LO   6
`define CGS_ST1_REFERENCE_STATUS     5
`define CGS_ST1_LOST_LOCK_FLAG      4
`define CGS_ST1_LOCK      3
`define CGS_ST1_LOST_CLOCK_FLAG      2
`define CGS_ST1_EXT_REF_STABLE      1
`define CGS_ST1_IF        0
// Status two field
`define CGS_ST2_OSCST     0
// Control fields
`define CGS_CTL_SEL_HI    1
`define CGS_CTL_SEL_LO    0
`define CGS_CTL_LOST_LOCK_RESET_ENABLE     2
`define CGS_CTL_LOST_CLOCK_RESET_ENABLE     3
`define CGS_CTL_LOCD      4
// Mode select codes
`define CGS_SEL_SCM       2'h0
`define CGS_SEL_FEI       2'h1
`define CGS_SEL_FBE       2'h2
`define CGS_SEL_FEE       2'h3
// Reset values
`define CGS_FLT_RST       12'h400
`define CGS_TRIM_POR      8'h80
// Timing, in ns, and clock period
`define CGS_CLK_PERIOD_NS 25
`define CGS_OSC_STATIC_NS 1000
`define CGS_FLT_LATCH_NS  100
`define CGS_MODE_SYNC_NS  50
`endif

// [core/cgs_pkg.sv]
// Types shared by the clock status block
`default_nettype none
package cgs_pkg;
  // Clock generator operating states
  typedef enum logic [2:0] {ST_OFF, ST_SCM, ST_FEI, ST_FBE, ST_FEE} cgs_state_e;
  // Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cgs_wb_req_s;
  // Loop measurements on the bus clock
  typedef struct packed {
    logic [7:0]  count_err;
    logic        err_valid;
    logic        filt_upd;
    logic [11:0] filt_val;
  } cgs_fll_s;
  // Levels arriving from outside the clock domain
  typedef struct packed {
    logic locked;
    logic ext_ok;
    logic crystal;
    logic osc_clk;
    logic stop;
  } cgs_pins_s;
endpackage : cgs_pkg
`default_nettype wire

// [core/cgs_sync3.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module cgs_sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Raw and filtered levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;  // Metastability catcher, read only by stage2
  logic [WIDTH-1:0] stage2;  // Second stage
  logic [WIDTH-1:0] stage3;  // Third stage

  // Shift chain
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a bit once the second and third stages agree
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end
endmodule : cgs_sync3
`default_nettype wire

// [core/cgs_top.sv]
// Status, filter and trim registers of the internal clock generator
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "cgs_defines.svh"
//
// Contract
// - Two-bit field reports current clock mode
// - Mode status lags select through synchronisation
// - Reference bit: 0 external clock, 1 crystal
// - Sticky lost-lock flag until cleared
// - Lock bit only when engaged and locked
// - Sticky lost-clock flag until cleared
// - External reference stable bit reported
// - Interrupt flag set while request pending
// - Flag cleared by reset or read-then-write-1
// - New event restarts the clear sequence
// - Writing zero leaves flag unchanged
// - Oscillator stable after two small-drift samples
// - Leaving off does not wait; engaging waits for stable oscillator
// - Self-clocked loss monitoring after oscillator stable
// - Oscillator stable cleared entering off
// - Twelve-bit filter split upper and lower
// - Filter writable only when select self-clocked
// - Upper write commits whole filter at once
// - Upper write ignored while latch busy
// - Trim sets reference period, larger longer
// - Trim untouched by system reset
// - Lost clock: interrupt or reset by enable
// - Lost lock: interrupt or reset by enable
module cgs_top #(
  parameter logic [7:0] UNLOCK_THRESH = 8'h04  // Allowed count error drift
) (
  // Clock and resets
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               por_rst,
  // Wishbone slave
  input  wire cgs_pkg::cgs_wb_req_s wb_req,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  // Clock generator side
  input  wire cgs_pkg::cgs_pins_s pins,
  input  wire cgs_pkg::cgs_fll_s  fll,
  // Control outputs
  output logic [11:0]             filter_value,
  output logic [7:0]              trim_value,
  output logic [1:0]              mode_status,
  output logic                    irq_req,
  output logic                    reset_req
);
  import cgs_pkg::*;

  // Cycle counts derived from times
  localparam int OSC_STATIC_CYC = (`CGS_OSC_STATIC_NS + `CGS_CLK_PERIOD_NS - 1)
                                  / `CGS_CLK_PERIOD_NS;
  localparam int LATCH_CYC      = (`CGS_FLT_LATCH_NS + `CGS_CLK_PERIOD_NS - 1)
                                  / `CGS_CLK_PERIOD_NS;
  localparam int MSYNC_CYC      = (`CGS_MODE_SYNC_NS + `CGS_CLK_PERIOD_NS - 1)
                                  / `CGS_CLK_PERIOD_NS;

  cgs_pins_s   pins_s;           // Synchronised pin levels
  cgs_state_e  state;            // Operating state
  logic [1:0]  mode_select;      // Software mode request
  logic [1:0]  applied_select;   // Request after crossing
  logic [3:0]  msync_cnt;        // Mode crossing countdown
  logic        lost_lock_reset_enable;            // Lost lock reset enable
  logic        lost_clock_reset_enable;            // Lost clock reset enable
  logic        locd;             // Loss of clock detection disable
  logic        lock_bit;         // Current lock status
  logic        lost_lock_flag;   // Sticky lost lock
  logic        lost_clock_flag;  // Sticky lost clock
  logic        irq_flag;         // Pending interrupt
  logic        clr_armed;        // Status read seen with flag set
  logic        osc_stable;       // Oscillator stable
  logic [7:0]  prev_err;         // Previous count error
  logic [1:0]  good_samples;     // Consecutive small-drift samples
  logic        osc_prev;         // Last oscillator level
  logic [7:0]  static_cnt;       // Cycles without oscillator edge
  logic        osc_static;       // Oscillator stopped
  logic [7:0]  flt_hold;         // Held lower filter byte
  logic [3:0]  latch_cnt;        // Filter latch busy counter
  logic        ext_prev;         // Last external stable level
  logic        access;           // New bus access this cycle
  logic        wr_en;            // Write access, low lane enabled
  logic        rd_st1;           // Read of status one
  logic        lock_lost_ev;     // Unexpected lock loss
  logic        clock_lost_ev;    // Loss of clock detected
  logic        monitor_en;       // Oscillator loss monitoring active
  logic [7:0]  status_one;       // Assembled status one
  logic [7:0]  control_rd;       // Assembled control readback

  // Absolute difference of two count errors
  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction : abs_diff

  // State to mode code
  function automatic logic [1:0] mode_code(input cgs_state_e s);
    unique case (s)
      ST_FEI:  mode_code = `CGS_SEL_FEI;
      ST_FBE:  mode_code = `CGS_SEL_FBE;
      ST_FEE:  mode_code = `CGS_SEL_FEE;
      ST_OFF,
      ST_SCM:  mode_code = `CGS_SEL_SCM;
      default: mode_code = `CGS_SEL_SCM;  // Unused state codes read as self-clocked
    endcase
  endfunction : mode_code

  // Pin synchroniser
  cgs_sync3 #(
    .WIDTH    ($bits(cgs_pins_s))
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (pins),
    .sync_out (pins_s)
  );

  // Bus decode
  assign access = wb_req.cyc && wb_req.stb && !wb_ack_o;
  assign wr_en  = access && wb_req.we && wb_req.sel[0];
  assign rd_st1 = access && !wb_req.we && (wb_req.adr == `CGS_ADR_STATUS1);

  // Event detection
  assign monitor_en    = ((state == ST_SCM) && osc_stable)
                         || (state == ST_FEI) || (state == ST_FEE);
  assign lock_lost_ev  = lock_bit && !pins_s.locked
                         && ((state == ST_FEI) || (state == ST_FEE));
  assign clock_lost_ev = !locd && ((monitor_en && osc_static)
                         || (ext_prev && !pins_s.ext_ok
                             && ((state == ST_FBE) || (state == ST_FEE))));

  // Status assembly
  always_comb begin
    status_one = 8'h00;
    status_one[`CGS_ST1_MODE_HI:`CGS_ST1_MODE_LO] = mode_code(state);
    status_one[`CGS_ST1_REFERENCE_STATUS] = pins_s.crystal;
    status_one[`CGS_ST1_LOST_LOCK_FLAG]  = lost_lock_flag;
    status_one[`CGS_ST1_LOCK]  = lock_bit;
    status_one[`CGS_ST1_LOST_CLOCK_FLAG]  = lost_clock_flag;
    status_one[`CGS_ST1_EXT_REF_STABLE]  = pins_s.ext_ok;
    status_one[`CGS_ST1_IF]    = irq_flag;
    control_rd = 8'h00;
    control_rd[`CGS_CTL_SEL_HI:`CGS_CTL_SEL_LO] = mode_select;
    control_rd[`CGS_CTL_LOST_LOCK_RESET_ENABLE] = lost_lock_reset_enable;
    control_rd[`CGS_CTL_LOST_CLOCK_RESET_ENABLE] = lost_clock_reset_enable;
    control_rd[`CGS_CTL_LOCD]  = locd;
  end

  // Bus answer: ack one cycle after request, read data with it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= 32'h0000_0000;
      if (access && !wb_req.we) begin
        unique case (wb_req.adr)
          `CGS_ADR_STATUS1:   wb_dat_o[7:0] <= status_one;
          `CGS_ADR_STATUS2:   wb_dat_o[`CGS_ST2_OSCST] <= osc_stable;
          `CGS_ADR_FLT_UPPER: wb_dat_o[3:0] <= filter_value[11:8];
          `CGS_ADR_FLT_LOWER: wb_dat_o[7:0] <= filter_value[7:0];
          `CGS_ADR_TRIM:      wb_dat_o[7:0] <= trim_value;
          `CGS_ADR_CONTROL:   wb_dat_o[7:0] <= control_rd;
          default:            wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register; a mode write is refused while the last one crosses
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_select <= `CGS_SEL_SCM;
      lost_lock_reset_enable       <= 1'b0;
      lost_clock_reset_enable       <= 1'b0;
      locd        <= 1'b0;
    end else if (wr_en && (wb_req.adr == `CGS_ADR_CONTROL)) begin
      lost_lock_reset_enable <= wb_req.dat[`CGS_CTL_LOST_LOCK_RESET_ENABLE];
      lost_clock_reset_enable <= wb_req.dat[`CGS_CTL_LOST_CLOCK_RESET_ENABLE];
      locd  <= wb_req.dat[`CGS_CTL_LOCD];
      if (msync_cnt == 4'h0) begin
        mode_select <= wb_req.dat[`CGS_CTL_SEL_HI:`CGS_CTL_SEL_LO];
      end
    end
  end

  // Mode request crossing delay
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      msync_cnt      <= 4'h0;
      applied_select <= `CGS_SEL_SCM;
    end else if (wr_en && (wb_req.adr == `CGS_ADR_CONTROL) && (msync_cnt == 4'h0)) begin
      msync_cnt <= 4'(MSYNC_CYC);
    end else if (msync_cnt == 4'h1) begin
      msync_cnt      <= 4'h0;
      applied_select <= mode_select;
    end else if (msync_cnt != 4'h0) begin
      msync_cnt <= msync_cnt - 4'h1;
    end
  end

  // Operating state machine
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_SCM;
    end else if (pins_s.stop) begin
      state <= ST_OFF;
    end else begin
      unique case (state)
        ST_OFF: begin
          // Leaving off with an engaged request passes through self-clocked
          if ((applied_select == `CGS_SEL_FBE) && pins_s.ext_ok) begin
            state <= ST_FBE;
          end else begin
            state <= ST_SCM;
          end
        end
        ST_SCM: begin
          if ((applied_select == `CGS_SEL_FEI) && osc_stable) begin
            state <= ST_FEI;
          end else if ((applied_select == `CGS_SEL_FEE) && osc_stable && pins_s.ext_ok) begin
            state <= ST_FEE;
          end else if ((applied_select == `CGS_SEL_FBE) && pins_s.ext_ok) begin
            state <= ST_FBE;
          end
        end
        ST_FEI: begin
          if (applied_select != `CGS_SEL_FEI) begin
            state <= ST_SCM;
          end
        end
        ST_FBE: begin
          if ((applied_select != `CGS_SEL_FBE) || clock_lost_ev) begin
            state <= ST_SCM;
          end
        end
        ST_FEE: begin
          if (clock_lost_ev) begin
            state <= pins_s.ext_ok ? ST_FBE : ST_SCM;
          end else if (applied_select != `CGS_SEL_FEE) begin
            state <= ST_SCM;
          end
        end
      endcase
    end
  end

  // Mode status output follows the state
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_status <= `CGS_SEL_SCM;
    end else begin
      mode_status <= mode_code(state);
    end
  end

  // Lock bit, forced low outside engaged modes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_bit <= 1'b0;
    end else begin
      lock_bit <= pins_s.locked && ((state == ST_FEI) || (state == ST_FEE));
    end
  end

  // Oscillator edge watch
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_prev   <= 1'b0;
      static_cnt <= 8'h00;
      osc_static <= 1'b1;
      ext_prev   <= 1'b0;
    end else begin
      osc_prev <= pins_s.osc_clk;
      ext_prev <= pins_s.ext_ok;
      if (osc_prev != pins_s.osc_clk) begin
        static_cnt <= 8'h00;
        osc_static <= 1'b0;
      end else if (static_cnt == 8'(OSC_STATIC_CYC)) begin
        osc_static <= 1'b1;
      end else begin
        static_cnt <= static_cnt + 8'h01;
      end
    end
  end

  // Oscillator stable: two small-drift samples while toggling
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_stable   <= 1'b0;
      prev_err     <= 8'h00;
      good_samples <= 2'h0;
    end else if ((state == ST_OFF) || osc_static) begin
      osc_stable   <= 1'b0;
      good_samples <= 2'h0;
    end else if (fll.err_valid) begin
      prev_err <= fll.count_err;
      if (abs_diff(fll.count_err, prev_err) <= UNLOCK_THRESH) begin
        if (good_samples == 2'h1) begin
          osc_stable <= 1'b1;
        end
        good_samples <= (good_samples == 2'h2) ? 2'h2 : good_samples + 2'h1;
      end else begin
        good_samples <= 2'h0;
      end
    end
  end

  // Sticky loss flags; software writes 1 to clear, a new loss wins
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lost_lock_flag  <= 1'b0;
      lost_clock_flag <= 1'b0;
    end else begin
      if (lock_lost_ev) begin
        lost_lock_flag <= 1'b1;
      end else if (wr_en && (wb_req.adr == `CGS_ADR_STATUS1)
                   && wb_req.dat[`CGS_ST1_LOST_LOCK_FLAG]) begin
        lost_lock_flag <= 1'b0;
      end
      if (clock_lost_ev) begin
        lost_clock_flag <= 1'b1;
      end else if (wr_en && (wb_req.adr == `CGS_ADR_STATUS1)
                   && wb_req.dat[`CGS_ST1_LOST_CLOCK_FLAG]) begin
        lost_clock_flag <= 1'b0;
      end
    end
  end

  // Interrupt flag with read-then-write-1 clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_flag  <= 1'b0;
      clr_armed <= 1'b0;
    end else if ((lock_lost_ev && !lost_lock_reset_enable) || (clock_lost_ev && !lost_clock_reset_enable)) begin
      irq_flag  <= 1'b1;
      clr_armed <= 1'b0;
    end else if (rd_st1 && irq_flag) begin
      clr_armed <= 1'b1;
    end else if (wr_en && (wb_req.adr == `CGS_ADR_STATUS1)) begin
      if (clr_armed && wb_req.dat[`CGS_ST1_IF]) begin
        irq_flag  <= 1'b0;
        clr_armed <= 1'b0;
      end
    end
  end

  // Interrupt and reset request outputs
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_req   <= 1'b0;
      reset_req <= 1'b0;
    end else begin
      irq_req <= irq_flag;
      if ((lock_lost_ev && lost_lock_reset_enable) || (clock_lost_ev && lost_clock_reset_enable)) begin
        reset_req <= 1'b1;
      end
    end
  end

  // Filter value: lower byte held, upper write commits all twelve bits
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      filter_value <= `CGS_FLT_RST;
      flt_hold     <= 8'h00;
      latch_cnt    <= 4'h0;
    end else begin
      if (latch_cnt != 4'h0) begin
        latch_cnt <= latch_cnt - 4'h1;
      end
      if (wr_en && (mode_select == `CGS_SEL_SCM)) begin
        if (wb_req.adr == `CGS_ADR_FLT_LOWER) begin
          flt_hold <= wb_req.dat[7:0];
        end else if ((wb_req.adr == `CGS_ADR_FLT_UPPER) && (latch_cnt == 4'h0)) begin
          filter_value <= {wb_req.dat[3:0], flt_hold};
          latch_cnt    <= 4'(LATCH_CYC);
        end
      end else if (fll.filt_upd && ((state == ST_FEI) || (state == ST_FEE))) begin
        filter_value <= fll.filt_val;
      end
    end
  end

  // Trim, kept across system reset, reset only at power-on
  always_ff @(posedge core_clk or posedge por_rst) begin
    if (por_rst) begin
      trim_value <= `CGS_TRIM_POR;
    end else if (wr_en && (wb_req.adr == `CGS_ADR_TRIM)) begin
      trim_value <= wb_req.dat[7:0];
    end
  end
endmodule : cgs_top
`default_nettype wire

// [sim/cgs_top_assertions.sv]
// Port checker for the clock status block, bound into its top module
`timescale 1ns/100ps
`default_nettype none
`include "cgs_defines.svh"
module cgs_top_chk (
  // Clock and resets
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  input wire logic                 por_rst,
  // Bus and loop side
  input wire cgs_pkg::cgs_wb_req_s wb_req,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire cgs_pkg::cgs_fll_s    fll,
  // Outputs watched
  input wire logic [11:0]          filter_value,
  input wire logic [7:0]           trim_value,
  input wire logic [1:0]           mode_status,
  input wire logic                 irq_req,
  input wire logic                 reset_req
);
  import cgs_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Request taken and write strobe
  wire logic taken = wb_req.cyc && wb_req.stb && !wb_ack_o;
  wire logic wr    = taken && wb_req.we && wb_req.sel[0];
  // Answer to a status one read while the mode has settled
  sequence st_rd;
    wb_ack_o && $past(taken && !wb_req.we && wb_req.adr == `CGS_ADR_STATUS1)
      && mode_status == $past(mode_status) && mode_status == $past(mode_status, 2);
  endsequence
  chk_ack_follows: assert property (taken |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero while idle");
  chk_trim_write_only: assert property (disable iff (por_rst)
    trim_value != $past(trim_value) |-> $past(wr && wb_req.adr == `CGS_ADR_TRIM))
    else $error("trim changed without a write");
  chk_filter_cause: assert property (filter_value != $past(filter_value)
    |-> $past(wr && wb_req.adr == `CGS_ADR_FLT_UPPER || fll.filt_upd))
    else $error("filter changed without an upper write");
  chk_irq_clear_cause: assert property ($fell(irq_req)
    |-> $past(wr && wb_req.adr == `CGS_ADR_STATUS1 && wb_req.dat[0], 2))
    else $error("interrupt dropped without a write of one");
  chk_reset_req_sticky: assert property (reset_req |=> reset_req)
    else $error("reset request dropped");
  chk_mode_field: assert property (st_rd |-> wb_dat_o[7:6] == mode_status)
    else $error("status mode field differs from mode output");
  chk_lock_forced: assert property (st_rd ##0 !mode_status[0] |-> !wb_dat_o[3])
    else $error("lock bit set outside engaged modes");
  cover property ($rose(irq_req));
  cover property ($rose(reset_req));
  cover property (filter_value != $past(filter_value));
endmodule : cgs_top_chk
bind cgs_top cgs_top_chk cgs_top_chk_i (.core_clk(core_clk), .sys_rst(sys_rst),
  .por_rst(por_rst), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fll(fll),
  .filter_value(filter_value), .trim_value(trim_value), .mode_status(mode_status),
  .irq_req(irq_req), .reset_req(reset_req));
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the clock status block
`timescale 1ns/100ps
`default_nettype none
`include "cgs_defines.svh"
module tb_top;
  import cgs_pkg::*;
  logic        core_clk = 1'b0;  // Bus clock
  logic        sys_rst  = 1'b1;  // System reset
  logic        por_rst  = 1'b1;  // Power-on reset
  cgs_wb_req_s wb_req   = '0;    // Bus request
  cgs_pins_s   pins     = '0;    // Outside levels
  cgs_fll_s    fll      = '0;    // Loop samples
  logic        osc_run  = 1'b0;  // Oscillator toggling
  logic [1:0]  osc_div  = 2'h0;  // Oscillator divider
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [11:0] filter_value;
  logic [7:0]  trim_value;
  logic [1:0]  mode_status;
  logic        irq_req;
  logic        reset_req;
  logic [7:0]  rd;               // Last read byte
  logic [1:0]  code;             // Mode under test
  logic [1:0]  prev;             // Previous mode
  int          fail_count = 0;
  int          checks     = 0;
  cgs_top cgs_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .por_rst(por_rst),
    .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins(pins), .fll(fll),
    .filter_value(filter_value), .trim_value(trim_value), .mode_status(mode_status),
    .irq_req(irq_req), .reset_req(reset_req));
  // Clock at 40 MHz
  always #12.5 core_clk = ~core_clk;
  // Slow oscillator so the input filter passes it
  always @(posedge core_clk) begin
    if (osc_run) begin
      osc_div <= osc_div + 2'h1;
      if (osc_div == 2'h3) pins.osc_clk <= ~pins.osc_clk;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic miss(input string msg);
    fail_count++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : miss
  // One classic bus cycle, held until ack is seen
  // A missing answer is left to the watchdog
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h0, d}};
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_req <= '0;
  endtask : wb_cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb_cycle(1'b1, a, d);
  endtask : wr
  // Register read compared under a mask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    wb_cycle(1'b0, a, 8'h00);
    checks++;
    if ((rd & m) !== e) miss("register read");
  endtask : rdc
  // Port value compare
  task automatic cmpp(input logic [11:0] got, input logic [11:0] e);
    checks++;
    if (got !== e) miss("port value");
  endtask : cmpp
  // Loop error samples of equal size
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge core_clk);
      fll.count_err <= 8'h10;
      fll.err_valid <= 1'b1;
      @(posedge core_clk);
      fll.err_valid <= 1'b0;
      tick(2);
    end
  endtask : pulses
  task automatic wrap_up;
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // Watchdog against a hang
  initial begin
    #500000;
    fail_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    tick(6);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    @(posedge core_clk);
    rdc(`CGS_ADR_FLT_UPPER, 8'hff, 8'h04);
    rdc(`CGS_ADR_FLT_LOWER, 8'hff, 8'h00);
    rdc(`CGS_ADR_TRIM, 8'hff, 8'h80);
    rdc(8'h20, 8'hff, 8'h00);
    tick(60);
    rdc(`CGS_ADR_STATUS1, 8'hff, 8'h00);
    // Lower byte held, upper commits, busy latch refuses
    wr(`CGS_ADR_FLT_LOWER, 8'h5a);
    cmpp(filter_value, 12'h400);
    wr(`CGS_ADR_FLT_UPPER, 8'h03);
    wr(`CGS_ADR_FLT_UPPER, 8'h07);
    tick(6);
    cmpp(filter_value, 12'h35a);
    wr(`CGS_ADR_FLT_UPPER, 8'h07);
    rdc(`CGS_ADR_FLT_UPPER, 8'h0f, 8'h07);
    rdc(`CGS_ADR_FLT_LOWER, 8'hff, 8'h5a);
    // Filter refused outside self-clocked select
    wr(`CGS_ADR_CONTROL, 8'h01);
    wr(`CGS_ADR_FLT_LOWER, 8'h11);
    wr(`CGS_ADR_FLT_UPPER, 8'h02);
    tick(6);
    cmpp(filter_value, 12'h75a);
    wr(`CGS_ADR_CONTROL, 8'h00);
    // Oscillator stable after two good samples
    osc_run <= 1'b1;
    tick(10);
    pulses(1);
    rdc(`CGS_ADR_STATUS2, 8'h01, 8'h00);
    pulses(2);
    rdc(`CGS_ADR_STATUS2, 8'h01, 8'h01);
    // Every mode code, with lag and status bits
    pins.locked <= 1'b1;
    pins.ext_ok <= 1'b1;
    pins.crystal <= 1'b1;
    prev = 2'h0;
    tick(8);
    for (int i = 1; i <= 4; i++) begin
      code = 2'(i);
      wr(`CGS_ADR_CONTROL, {6'h0, code});
      cmpp({10'h0, mode_status}, {10'h0, prev});
      tick(8);
      cmpp({10'h0, mode_status}, {10'h0, code});
      rdc(`CGS_ADR_STATUS1, 8'hea, {code, 2'b10, code[0], 3'b010});
      prev = code;
    end
    rdc(`CGS_ADR_STATUS1, 8'hff, 8'h22);
    wr(`CGS_ADR_STATUS1, 8'h15);
    // Loss of a stable oscillator in self-clocked mode
    osc_run <= 1'b0;
    tick(70);
    cmpp({11'h0, irq_req}, 12'h001);
    cmpp({11'h0, reset_req}, 12'h000);
    wr(`CGS_ADR_STATUS1, 8'h01);
    tick(3);
    cmpp({11'h0, irq_req}, 12'h001);
    rdc(`CGS_ADR_STATUS1, 8'h05, 8'h05);
    wr(`CGS_ADR_STATUS1, 8'h00);
    tick(3);
    cmpp({11'h0, irq_req}, 12'h001);
    rdc(`CGS_ADR_STATUS1, 8'h05, 8'h05);
    wr(`CGS_ADR_STATUS1, 8'h05);
    tick(3);
    cmpp({11'h0, irq_req}, 12'h000);
    rdc(`CGS_ADR_STATUS1, 8'h05, 8'h00);
    // Off state clears stability, re-engaging waits for it
    osc_run <= 1'b1;
    tick(10);
    pulses(3);
    wr(`CGS_ADR_CONTROL, 8'h01);
    tick(8);
    pins.stop <= 1'b1;
    tick(10);
    pins.stop <= 1'b0;
    tick(10);
    cmpp({10'h0, mode_status}, 12'h000);
    rdc(`CGS_ADR_STATUS2, 8'h01, 8'h00);
    pulses(3);
    tick(8);
    cmpp({10'h0, mode_status}, 12'h001);
    // Loop update of the filter while engaged
    fll.filt_val <= 12'h2c7;
    fll.filt_upd <= 1'b1;
    @(posedge core_clk);
    fll.filt_upd <= 1'b0;
    tick(2);
    cmpp(filter_value, 12'h2c7);
    // Lost lock, a second event during the clear
    rdc(`CGS_ADR_STATUS1, 8'hff, 8'h6a);
    wr(`CGS_ADR_STATUS1, 8'h15);
    pins.locked <= 1'b0;
    tick(10);
    rdc(`CGS_ADR_STATUS1, 8'h19, 8'h11);
    pins.locked <= 1'b1;
    tick(10);
    pins.locked <= 1'b0;
    tick(10);
    wr(`CGS_ADR_STATUS1, 8'h01);
    tick(3);
    cmpp({11'h0, irq_req}, 12'h001);
    cmpp({11'h0, reset_req}, 12'h000);
    wr(`CGS_ADR_CONTROL, 8'h05);
    pins.locked <= 1'b1;
    tick(10);
    pins.locked <= 1'b0;
    tick(10);
    cmpp({11'h0, reset_req}, 12'h001);
    // Trim survives a system reset
    wr(`CGS_ADR_TRIM, 8'h3c);
    tick(2);
    cmpp({4'h0, trim_value}, 12'h03c);
    sys_rst <= 1'b1;
    tick(3);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    cmpp({10'h0, irq_req, reset_req}, 12'h000);
    rdc(`CGS_ADR_TRIM, 8'hff, 8'h3c);
    rdc(`CGS_ADR_FLT_UPPER, 8'h0f, 8'h04);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
